// File: scfc_buf.sv
// Two-entry transmit buffer; the head entry drives the outputs directly.
// Assumes a single clock and a synchronous active-high reset.
`include "scfc_cfg.svh"

module scfc_buf #(
    parameter int unsigned DEPTH = `SCFC_BUF_DEPTH
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Filling side
    scfc_strm_if.snk in_s,
    // Draining side
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i
);

    typedef struct packed {
        logic [DEPTH-1:0] vld;
        logic [DEPTH-1:0][7:0] mem;
    } scfc_buf_s;

    scfc_buf_s q, d;

    // ==========================================================
    // Shift down on pop, write into the lowest free slot on push
    always_comb begin
        int w;
        w = 0;
        d = q;
        if (q.vld[0] && tx_ready_i) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                d.vld[i] = q.vld[i+1];
                d.mem[i] = q.mem[i+1];
            end
            d.vld[DEPTH-1] = 1'b0;
        end
        // Full is judged before the pop so the ready path stays short
        if (in_s.valid && !q.vld[DEPTH-1]) begin
            for (int i = DEPTH - 1; i >= 0; i--) begin
                if (!d.vld[i]) begin
                    w = i;
                end
            end
            d.vld[w] = 1'b1;
            d.mem[w] = in_s.data;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_s.ready = !q.vld[DEPTH-1];
    assign tx_valid_o = q.vld[0];
    assign tx_data_o = q.mem[0];

endmodule

// File: scfc_cfg.svh
// Constants of the serial command frame checker: codes, characters, layout, limits.
// Assumes 8-bit characters from an external receiver and a 25 MHz clock.
`ifndef SCFC_CFG_SVH
`define SCFC_CFG_SVH

// ==========================================================
// Error codes sent back in the negative reply
`define SCFC_E_SYS 16'h0001
`define SCFC_E_DATA 16'h0011
`define SCFC_E_CMD 16'h0021
`define SCFC_E_TYPE 16'h0031
`define SCFC_E_AREA 16'h1132
`define SCFC_E_SIZE 16'h1232
`define SCFC_E_DTYPE 16'h2432
`define SCFC_E_FMT 16'h7132
`define SCFC_E_RANGE 16'h2232
`define SCFC_E_MEXE 16'h0190
`define SCFC_E_MREG 16'h0290
`define SCFC_E_FORM 16'h6001
`define SCFC_E_LINE 16'h6010
`define SCFC_E_TMO 16'h6020
`define SCFC_E_SYN 16'h6030
`define SCFC_E_LEN 16'h6040
`define SCFC_E_BCC 16'h6050
`define SCFC_E_NONE 16'h0000

// ==========================================================
// Characters
`define SCFC_ENQ 8'h05
`define SCFC_EOT 8'h04
`define SCFC_ACK 8'h06
`define SCFC_NAK 8'h15
`define SCFC_ETX 8'h03
`define SCFC_PCT 8'h25
`define SCFC_ASC_0 8'h30
`define SCFC_ASC_9 8'h39
`define SCFC_ASC_UA 8'h41
`define SCFC_ASC_UF 8'h46
`define SCFC_ASC_LA 8'h61
`define SCFC_ASC_LF 8'h66
`define SCFC_ASC_HEX_OFS 8'h37
`define SCFC_ASC_LHEX_OFS 8'h57
`define SCFC_UPPER_MASK 8'hDF

// ==========================================================
// Field positions within the frame text and least text lengths
`define SCFC_FLD_N 14
`define SCFC_P_STN 0
`define SCFC_P_CMD 2
`define SCFC_P_TYP 3
`define SCFC_P_REG 5
`define SCFC_P_PCT 5
`define SCFC_P_AREA 6
`define SCFC_P_DTY 7
`define SCFC_P_ADR 8
`define SCFC_P_CNT 12
`define SCFC_LEN_STS 9'd5
`define SCFC_LEN_MON 9'd7
`define SCFC_LEN_RW 9'd14

// ==========================================================
// Limits and timing
`define SCFC_MAX_TEXT 9'd256
`define SCFC_MAX_CNT 8'h80
`define SCFC_MAX_REG 8'h09
`define SCFC_AREA_LIM 16'h0400
`define SCFC_TIMEOUT_US 1000
`define SCFC_CLK_KHZ 25000
`define SCFC_TIMEOUT_CYC ((`SCFC_TIMEOUT_US * `SCFC_CLK_KHZ) / 1000)
`define SCFC_BUF_DEPTH 2
`define SCFC_RPL_ACK_LAST 3'h3
`define SCFC_RPL_NAK_LAST 3'h7

`endif

// File: scfc_host.sv
// Host model that sends command frames to the checker.
// Assumes its tasks are called just after a rising clock edge.
module scfc_host (
    // Clock
    input wire logic clock_i,
    // Receive link
    input wire logic rx_ready_i,
    output logic valid_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        valid_o = 1'b0;
        data_o = 8'hFF;
    end
    // ==========================================================
    // Byte transfer, held until taken
    task automatic put(input logic [7:0] b);
        valid_o = 1'b1;
        data_o = b;
        do @(posedge clock_i); while (rx_ready_i !== 1'b1);
        #1;
    endtask
    // Released data toggles so no stale byte looks valid
    task automatic idle();
        valid_o = 1'b0;
        data_o = ~data_o;
    endtask
    // Text length is the caller's choice
    task automatic send(input string t, input bit bad, input bit enq);
        logic [7:0] sum;
        string h;
        sum = 8'h05;
        if (enq) put(8'h05);
        foreach (t[i]) begin
            put(t[i]);
            sum = sum + t[i];
        end
        put(8'h04);
        sum = sum + 8'h04;
        if (bad) sum = ~sum;
        h = $sformatf("%02X", sum);
        put(h[0]);
        put(h[1]);
        idle();
    endtask
endmodule

// File: scfc_pkg.sv
// Types and shared conversions of the serial command frame checker.
// Assumes scfc_cfg.svh is on the include path.
`include "scfc_cfg.svh"

package scfc_pkg;

    // ==========================================================
    // Types
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_BODY = 5'h02,
        ST_BCC = 5'h04,
        ST_CHECK = 5'h08,
        ST_REPLY = 5'h10
    } scfc_state_e;

    typedef logic [7:0] scfc_byte_t;

    typedef struct packed {
        scfc_state_e st;
        logic [8:0] pos;
        logic [`SCFC_FLD_N-1:0][7:0] fld;
        logic [7:0] sum;
        logic [7:0] bcc;
        logic bcc_n;
        logic [15:0] tmr;
        logic line_f;
        logic len_f;
        logic syn_f;
        logic bcc_f;
        logic rx_rdy;
        logic exec;
        logic err_vld;
        logic [15:0] err_code;
        logic start;
        logic nak;
        scfc_byte_t cmd;
        scfc_byte_t area;
        logic [15:0] addr;
        scfc_byte_t cnt;
    } scfc_top_s;

    typedef struct packed {
        logic busy;
        logic [2:0] idx;
        logic nak;
        logic [15:0] stn;
        logic [15:0] code;
    } scfc_rpl_s;

    // ==========================================================
    // Conversions
    // Valid flag in bit 4, value in the low nibble
    function automatic logic [4:0] hex_val(input scfc_byte_t c);
        if (c >= `SCFC_ASC_0 && c <= `SCFC_ASC_9) begin
            hex_val = {1'b1, 4'(c - `SCFC_ASC_0)};
        end else if (c >= `SCFC_ASC_UA && c <= `SCFC_ASC_UF) begin
            hex_val = {1'b1, 4'(c - `SCFC_ASC_HEX_OFS)};
        end else if (c >= `SCFC_ASC_LA && c <= `SCFC_ASC_LF) begin
            hex_val = {1'b1, 4'(c - `SCFC_ASC_LHEX_OFS)};
        end else begin
            hex_val = 5'h00;
        end
    endfunction

    function automatic scfc_byte_t nib_asc(input logic [3:0] n);
        if (n > 4'h9) begin
            nib_asc = 8'({4'h0, n}) + `SCFC_ASC_HEX_OFS;
        end else begin
            nib_asc = 8'({4'h0, n}) + `SCFC_ASC_0;
        end
    endfunction

endpackage

// File: scfc_reply.sv
// Reply sender: ACK or NAK, echoed station, error code digits for NAK, then ETX.
// Assumes start_i is a one-cycle pulse given only while busy_o is low.
`include "scfc_cfg.svh"

module scfc_reply (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Request
    input wire logic start_i,
    input wire logic nak_i,
    input wire logic [15:0] stn_i,
    input wire logic [15:0] code_i,
    output logic busy_o,
    // Byte stream out
    scfc_strm_if.src out_s
);

    scfc_pkg::scfc_rpl_s q, d;
    logic [2:0] last;

    assign last = q.nak ? `SCFC_RPL_NAK_LAST : `SCFC_RPL_ACK_LAST;

    // ==========================================================
    // Sequencer
    always_comb begin
        d = q;
        if (!q.busy) begin
            if (start_i) begin
                d.busy = 1'b1;
                d.idx = 3'h0;
                d.nak = nak_i;
                d.stn = stn_i;
                d.code = code_i;
            end
        end else if (out_s.ready) begin
            if (q.idx == last) begin
                d.busy = 1'b0;
            end else begin
                d.idx = q.idx + 3'h1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        case (q.idx)
            3'h0: out_s.data = q.nak ? `SCFC_NAK : `SCFC_ACK;
            3'h1: out_s.data = q.stn[15:8];
            3'h2: out_s.data = q.stn[7:0];
            3'h3: out_s.data = q.nak ? scfc_pkg::nib_asc(q.code[15:12]) : `SCFC_ETX;
            3'h4: out_s.data = scfc_pkg::nib_asc(q.code[11:8]);
            3'h5: out_s.data = scfc_pkg::nib_asc(q.code[7:4]);
            3'h6: out_s.data = scfc_pkg::nib_asc(q.code[3:0]);
            default: out_s.data = `SCFC_ETX;
        endcase
    end

    assign out_s.valid = q.busy;
    assign busy_o = q.busy;

endmodule

// File: scfc_strm_if.sv
// Byte stream between the reply sender and the transmit buffer.
// Assumes both ends share one clock; a byte moves when valid and ready are high.
interface scfc_strm_if;
    logic valid;
    logic ready;
    logic [7:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: scfc_top.sv
// Serial command frame checker: receives a frame, checks it, answers ACK or NAK.
// Assumes received bytes and line error flags arrive synchronous to clock_i.
//
// Overview of operation
// - Unreachable system interface gives code 0001.
// - Failed ASCII to number conversion gives code 0011.
// - Only write, read, monitor register, execute, status letters, any case; else 0021.
// - Command type must be SS or SB; else 0031.
// - Area letter must be one of nine areas; else 1132.
// - Data count zero or above 128 gives 1232.
// - Only bit and word data types; others give 2432.
// - Device name must start with percent; else 7132.
// - Address or address plus count beyond the area gives 2232.
// - Monitor register number above 9 gives 0290 registering, 0190 executing.
// - Device form unsupported by the command gives 6001.
// - Receiver overrun or character framing error gives 6010.
// - No byte for the timeout period while a frame is open gives 6020.
// - Frame opens with ENQ, closes with EOT; bad syntax gives 6030.
// - Frame text above 256 bytes gives 6040.
// - Block check mismatch gives 6050.
`include "scfc_cfg.svh"

module scfc_top #(
    parameter int unsigned TIMEOUT_CYC = `SCFC_TIMEOUT_CYC,
    parameter logic [15:0] AREA_LIMIT = `SCFC_AREA_LIM
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Receiver
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_overrun_i,
    input wire logic rx_frame_err_i,
    output logic rx_ready_o,
    // System interface
    input wire logic sys_ready_i,
    // Accepted command
    output logic exec_o,
    output logic [7:0] cmd_o,
    output logic [7:0] area_o,
    output logic [15:0] addr_o,
    output logic [7:0] count_o,
    // Rejection
    output logic err_valid_o,
    output logic [15:0] err_code_o,
    // Reply bytes
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i
);

    localparam logic [15:0] TMO_LIM = 16'(TIMEOUT_CYC);

    scfc_pkg::scfc_top_s q, d;
    scfc_strm_if rpl_s ();
    logic rpl_busy;

    function automatic logic dec_ok(input logic [7:0] c);
        dec_ok = (c >= `SCFC_ASC_0) && (c <= `SCFC_ASC_9);
    endfunction

    function automatic logic [15:0] dec_val(input logic [7:0] c);
        dec_val = {8'h00, c - `SCFC_ASC_0};
    endfunction

    // ==========================================================
    // Field decode
    logic [7:0] cmd_up, area_c, dty_c;
    logic cmd_ok, is_rw, is_mon, is_exe, type_ok, blk_type;
    logic [4:0] stn_h, stn_l, cnt_h, cnt_l, reg_h, reg_l, bcc_h, bcc_l;
    logic stn_ok, cnt_num_ok, reg_num_ok, adr_ok, area_ok, dty_ok, pct_ok, short_f;
    logic [7:0] cnt_v, reg_v;
    logic [15:0] adr_v, end_v, chk_code;
    logic syn_all, frame_ok, pre_ok;

    assign cmd_up = q.fld[`SCFC_P_CMD] & `SCFC_UPPER_MASK;
    assign is_rw = (cmd_up == "W") || (cmd_up == "R");
    assign is_mon = (cmd_up == "X") || (cmd_up == "Y");
    assign is_exe = (cmd_up == "Y");
    assign cmd_ok = is_rw || is_mon || (cmd_up == "S");
    assign blk_type = (q.fld[`SCFC_P_TYP+1] == "B");
    assign type_ok = (q.fld[`SCFC_P_TYP] == "S")
                     && (blk_type || (q.fld[`SCFC_P_TYP+1] == "S"));

    assign stn_h = scfc_pkg::hex_val(q.fld[`SCFC_P_STN]);
    assign stn_l = scfc_pkg::hex_val(q.fld[`SCFC_P_STN+1]);
    assign cnt_h = scfc_pkg::hex_val(q.fld[`SCFC_P_CNT]);
    assign cnt_l = scfc_pkg::hex_val(q.fld[`SCFC_P_CNT+1]);
    assign reg_h = scfc_pkg::hex_val(q.fld[`SCFC_P_REG]);
    assign reg_l = scfc_pkg::hex_val(q.fld[`SCFC_P_REG+1]);
    assign bcc_h = scfc_pkg::hex_val(q.bcc);
    assign bcc_l = scfc_pkg::hex_val(rx_data_i);
    assign stn_ok = stn_h[4] && stn_l[4];
    assign cnt_num_ok = cnt_h[4] && cnt_l[4];
    assign reg_num_ok = reg_h[4] && reg_l[4];
    assign cnt_v = {cnt_h[3:0], cnt_l[3:0]};
    assign reg_v = {reg_h[3:0], reg_l[3:0]};
    assign adr_ok = dec_ok(q.fld[`SCFC_P_ADR]) && dec_ok(q.fld[`SCFC_P_ADR+1])
                    && dec_ok(q.fld[`SCFC_P_ADR+2]) && dec_ok(q.fld[`SCFC_P_ADR+3]);
    assign adr_v = 16'(dec_val(q.fld[`SCFC_P_ADR]) * 16'd1000
                   + dec_val(q.fld[`SCFC_P_ADR+1]) * 16'd100
                   + dec_val(q.fld[`SCFC_P_ADR+2]) * 16'd10
                   + dec_val(q.fld[`SCFC_P_ADR+3]));
    assign end_v = adr_v + {8'h00, cnt_v};

    assign pct_ok = (q.fld[`SCFC_P_PCT] == `SCFC_PCT);
    assign area_c = q.fld[`SCFC_P_AREA];
    assign area_ok = (area_c == "P") || (area_c == "M") || (area_c == "L")
                     || (area_c == "K") || (area_c == "T") || (area_c == "C")
                     || (area_c == "F") || (area_c == "D") || (area_c == "S");
    assign dty_c = q.fld[`SCFC_P_DTY];
    assign dty_ok = (dty_c == "X") || (dty_c == "W");

    // Too short for its command counts as bad frame syntax
    assign short_f = q.pos < (is_rw ? `SCFC_LEN_RW : is_mon ? `SCFC_LEN_MON : `SCFC_LEN_STS);
    assign syn_all = q.syn_f || short_f;
    assign frame_ok = !q.line_f && !q.len_f && !syn_all && !q.bcc_f;
    assign pre_ok = frame_ok && sys_ready_i && cmd_ok && type_ok && stn_ok;

    // ==========================================================
    // Check order: frame-level first, then content
    assign chk_code =
        q.line_f ? `SCFC_E_LINE :
        q.len_f ? `SCFC_E_LEN :
        syn_all ? `SCFC_E_SYN :
        q.bcc_f ? `SCFC_E_BCC :
        !sys_ready_i ? `SCFC_E_SYS :
        !cmd_ok ? `SCFC_E_CMD :
        !type_ok ? `SCFC_E_TYPE :
        !stn_ok ? `SCFC_E_DATA :
        is_mon ? (!reg_num_ok ? `SCFC_E_DATA :
                  reg_v > `SCFC_MAX_REG ? (is_exe ? `SCFC_E_MEXE : `SCFC_E_MREG) :
                  `SCFC_E_NONE) :
        !is_rw ? `SCFC_E_NONE :
        !pct_ok ? `SCFC_E_FMT :
        !area_ok ? `SCFC_E_AREA :
        !dty_ok ? `SCFC_E_DTYPE :
        !(adr_ok && cnt_num_ok) ? `SCFC_E_DATA :
        (cnt_v == 8'h00 || cnt_v > `SCFC_MAX_CNT) ? `SCFC_E_SIZE :
        (blk_type && dty_c == "X") ? `SCFC_E_FORM :
        (end_v > AREA_LIMIT) ? `SCFC_E_RANGE :
        `SCFC_E_NONE;

    // ==========================================================
    // Frame sequencer
    always_comb begin
        d = q;
        d.exec = 1'b0;
        d.err_vld = 1'b0;
        d.start = 1'b0;
        case (q.st)
            scfc_pkg::ST_IDLE: begin
                d.rx_rdy = 1'b1;
                // Anything before ENQ is line noise and is dropped
                if (rx_valid_i && q.rx_rdy && rx_data_i == `SCFC_ENQ) begin
                    d.st = scfc_pkg::ST_BODY;
                    d.pos = '0;
                    d.sum = rx_data_i;
                    d.tmr = '0;
                    d.line_f = 1'b0;
                    d.len_f = 1'b0;
                    d.syn_f = 1'b0;
                    d.bcc_f = 1'b0;
                    d.bcc_n = 1'b0;
                end
            end
            scfc_pkg::ST_BODY, scfc_pkg::ST_BCC: begin
                d.tmr = q.tmr + 16'h0001;
                if (rx_overrun_i || rx_frame_err_i) begin
                    d.line_f = 1'b1;
                end
                if (q.tmr >= TMO_LIM) begin
                    d.st = scfc_pkg::ST_REPLY;
                    d.rx_rdy = 1'b0;
                    d.err_vld = 1'b1;
                    d.err_code = q.line_f ? `SCFC_E_LINE : `SCFC_E_TMO;
                    d.nak = 1'b1;
                    d.start = 1'b1;
                end else if (rx_valid_i) begin
                    d.tmr = '0;
                    if (q.st == scfc_pkg::ST_BODY) begin
                        d.sum = q.sum + rx_data_i;
                        if (rx_data_i == `SCFC_EOT) begin
                            d.st = scfc_pkg::ST_BCC;
                        end else begin
                            if (rx_data_i == `SCFC_ENQ) begin
                                d.syn_f = 1'b1;
                            end
                            if (q.pos < 9'(`SCFC_FLD_N)) begin
                                d.fld[q.pos[3:0]] = rx_data_i;
                            end
                            // Position saturates; later bytes only keep the flag up
                            if (q.pos == `SCFC_MAX_TEXT) begin
                                d.len_f = 1'b1;
                            end else begin
                                d.pos = q.pos + 9'h001;
                            end
                        end
                    end else if (!q.bcc_n) begin
                        d.bcc = rx_data_i;
                        d.bcc_n = 1'b1;
                    end else begin
                        d.bcc_f = !(bcc_h[4] && bcc_l[4]
                                    && {bcc_h[3:0], bcc_l[3:0]} == q.sum);
                        d.st = scfc_pkg::ST_CHECK;
                        d.rx_rdy = 1'b0;
                    end
                end
            end
            scfc_pkg::ST_CHECK: begin
                d.st = scfc_pkg::ST_REPLY;
                d.start = 1'b1;
                if (chk_code != `SCFC_E_NONE) begin
                    d.err_vld = 1'b1;
                    d.err_code = chk_code;
                    d.nak = 1'b1;
                end else begin
                    d.exec = 1'b1;
                    d.nak = 1'b0;
                    d.cmd = cmd_up;
                    d.area = area_c;
                    d.addr = adr_v;
                    d.cnt = cnt_v;
                end
            end
            scfc_pkg::ST_REPLY: begin
                // Reply is handed fully to the transmit buffer before the next frame is taken
                if (!rpl_busy && !q.start) begin
                    d.st = scfc_pkg::ST_IDLE;
                    d.rx_rdy = 1'b1;
                end
            end
            default: begin
                d.st = scfc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            q <= '{st: scfc_pkg::ST_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Reply path
    scfc_reply u_reply (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .start_i(q.start),
        .nak_i(q.nak),
        .stn_i({q.fld[`SCFC_P_STN], q.fld[`SCFC_P_STN+1]}),
        .code_i(q.err_code),
        .busy_o(rpl_busy),
        .out_s(rpl_s.src)
    );

    scfc_buf #(
        .DEPTH(`SCFC_BUF_DEPTH)
    ) u_buf (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_s(rpl_s.snk),
        .tx_valid_o(tx_valid_o),
        .tx_data_o(tx_data_o),
        .tx_ready_i(tx_ready_i)
    );

    assign rx_ready_o = q.rx_rdy;
    assign exec_o = q.exec;
    assign cmd_o = q.cmd;
    assign area_o = q.area;
    assign addr_o = q.addr;
    assign count_o = q.cnt;
    assign err_valid_o = q.err_vld;
    assign err_code_o = q.err_code;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    a_sys_link_err: assert property (q.st == scfc_pkg::ST_CHECK && frame_ok && !sys_ready_i
        |=> err_valid_o && err_code_o == `SCFC_E_SYS) else $error("system error code missing");
    a_cmd_letter: assert property (q.st == scfc_pkg::ST_CHECK && frame_ok && sys_ready_i
        && !cmd_ok |=> err_code_o == `SCFC_E_CMD) else $error("bad command letter not flagged");
    a_type_chars: assert property (q.st == scfc_pkg::ST_CHECK && frame_ok && sys_ready_i
        && cmd_ok && !type_ok |=> err_code_o == `SCFC_E_TYPE) else $error("bad type not flagged");
    a_mon_limit: assert property (q.st == scfc_pkg::ST_CHECK && pre_ok && is_mon && reg_num_ok
        && reg_v > `SCFC_MAX_REG |=> err_code_o == (is_exe ? `SCFC_E_MEXE : `SCFC_E_MREG))
        else $error("monitor limit not flagged");
    a_line_first: assert property (q.st == scfc_pkg::ST_CHECK && q.line_f
        |=> err_valid_o && err_code_o == `SCFC_E_LINE) else $error("line error not first");
    a_len_order: assert property (q.st == scfc_pkg::ST_CHECK && !q.line_f && q.len_f
        |=> err_code_o == `SCFC_E_LEN) else $error("length error misplaced");
    a_bcc_err: assert property (q.st == scfc_pkg::ST_CHECK && !q.line_f && !q.len_f
        && !syn_all && q.bcc_f |=> err_code_o == `SCFC_E_BCC) else $error("bcc error missed");
    a_timeout_err: assert property ((q.st == scfc_pkg::ST_BODY || q.st == scfc_pkg::ST_BCC)
        && q.tmr >= TMO_LIM && !q.line_f |=> err_valid_o && err_code_o == `SCFC_E_TMO
        ##1 !rx_ready_o) else $error("timeout not reported");
    a_reject_quiet: assert property (err_valid_o |-> !exec_o ##1 !exec_o && rpl_busy)
        else $error("rejected command executed");

endmodule

// File: serial_command_frame_checker_bench.sv
// Self-checking bench of the frame checker top.
// Assumes scfc_top, scfc_host and their includes are compiled first.
module serial_command_frame_checker_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i, rst_i, rx_valid_i, rx_overrun_i, rx_frame_err_i, rx_ready_o, sys_ready_i;
    logic exec_o, err_valid_o, tx_valid_o, tx_ready_i;
    logic [7:0] rx_data_i, cmd_o, area_o, count_o, tx_data_o;
    logic [15:0] addr_o, err_code_o;
    int error_cnt = 0;
    int comparisons = 0;
    // Short timeout keeps the run brief
    scfc_top #(.TIMEOUT_CYC(50)) i_scfc_top (.clock_i, .rst_i, .rx_valid_i, .rx_data_i,
        .rx_overrun_i, .rx_frame_err_i, .rx_ready_o, .sys_ready_i, .exec_o, .cmd_o, .area_o,
        .addr_o, .count_o, .err_valid_o, .err_code_o, .tx_valid_o, .tx_data_o, .tx_ready_i);
    scfc_host i_scfc_host (.clock_i, .rx_ready_i(rx_ready_o), .valid_o(rx_valid_i),
        .data_o(rx_data_i));
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // ==========================================================
    // Shared checks
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic get(output logic [7:0] b);
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (!(tx_valid_o === 1'b1 && tx_ready_i) && n < 300);
        chk("tx handshake", 16'h0001, 16'(tx_valid_o === 1'b1 && tx_ready_i === 1'b1));
        b = tx_data_o;
        #1;
    endtask
    // Outcome then reply; code zero means accepted
    task automatic outcome(input logic [15:0] c);
        int n;
        logic [7:0] b;
        string s;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (exec_o !== 1'b1 && err_valid_o !== 1'b1 && n < 300);
        chk("outcome", 16'h0001, 16'(exec_o === 1'b1 || err_valid_o === 1'b1));
        chk("exec", 16'(c == 16'h0000), 16'(exec_o));
        if (c != 16'h0000) chk("code", c, err_code_o);
        #1;
        s = (c != 16'h0000) ? $sformatf("00%04X", c) : "00";
        get(b);
        chk("head", (c != 16'h0000) ? 16'h0015 : 16'h0006, 16'(b));
        foreach (s[i]) begin
            get(b);
            chk("reply", 16'(s[i]), 16'(b));
        end
        get(b);
        chk("tail", 16'h0003, 16'(b));
    endtask
    task automatic run(input string t, input bit bad, input logic [15:0] c);
        i_scfc_host.send(t, bad, 1'b1);
        outcome(c);
    endtask
    // ==========================================================
    // Scenarios
    task automatic good_write();
        tx_ready_i = 1'b0;
        fork
            begin
                repeat (60) @(posedge clock_i);
                #1 tx_ready_i = 1'b1;
            end
        join_none
        run("00WSS%MW001001", 1'b0, 16'h0000);
        chk("cmd", 16'h0057, 16'(cmd_o));
        chk("area", 16'h004D, 16'(area_o));
        chk("addr", 16'h000A, addr_o);
        chk("count", 16'h0001, 16'(count_o));
    endtask
    task automatic letters();
        run("00rSS%PX000101", 1'b0, 16'h0000);
        chk("cmd", 16'h0052, 16'(cmd_o));
        run("00sSS", 1'b0, 16'h0000);
        run("00xSS09", 1'b0, 16'h0000);
        run("00YSS00", 1'b0, 16'h0000);
        run("00QSS%MW001001", 1'b0, 16'h0021);
    endtask
    task automatic content();
        run("00WSX%MW001001", 1'b0, 16'h0031);
        run("00WSS%QW001001", 1'b0, 16'h1132);
        run("00WSS%MW001000", 1'b0, 16'h1232);
        run("00WSS%MW001081", 1'b0, 16'h1232);
        run("00WSS%MD001001", 1'b0, 16'h2432);
        run("00WSS#MW001001", 1'b0, 16'h7132);
        run("00WSS%MW102401", 1'b0, 16'h2232);
        run("00XSS0A", 1'b0, 16'h0290);
        run("00ySS0A", 1'b0, 16'h0190);
        run("00XSS0G", 1'b0, 16'h0011);
        run("00RSB%MX001001", 1'b0, 16'h6001);
    endtask
    task automatic line();
        string s;
        s = "00SSS";
        repeat (252) s = {s, "0"};
        run("00WSS%MW001001", 1'b1, 16'h6050);
        run("00RS", 1'b0, 16'h6030);
        run(s, 1'b0, 16'h6040);
        i_scfc_host.put(8'h05);
        i_scfc_host.put(8'h30);
        i_scfc_host.put(8'h30);
        i_scfc_host.idle();
        outcome(16'h6020);
        for (int k = 0; k < 2; k++) begin
            i_scfc_host.put(8'h05);
            i_scfc_host.idle();
            rx_overrun_i = (k == 0);
            rx_frame_err_i = (k == 1);
            @(posedge clock_i);
            #1 rx_overrun_i = 1'b0;
            rx_frame_err_i = 1'b0;
            i_scfc_host.send("00WSS%MW001001", 1'b1, 1'b0);
            outcome(16'h6010);
        end
    endtask
    task automatic sys();
        sys_ready_i = 1'b0;
        run("00WSS%MW001001", 1'b0, 16'h0001);
        sys_ready_i = 1'b1;
    endtask
    initial begin
        rst_i = 1'b1;
        rx_overrun_i = 1'b0;
        rx_frame_err_i = 1'b0;
        sys_ready_i = 1'b1;
        tx_ready_i = 1'b1;
        repeat (6) @(posedge clock_i);
        #1 rst_i = 1'b0;
        good_write();
        letters();
        content();
        line();
        sys();
        tally_and_finish();
    end
    // Watchdog, well above the expected run
    initial begin
        #1000000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
